// ### adc_lp_defs.svh
/*
 * register offsets, field positions, reset values and timing counts of the
 * converter control block; assumes inclusion by bare name, no processes here
 */
`ifndef ADC_LP_DEFS_SVH
`define ADC_LP_DEFS_SVH

`define OFS_CFG        3'h0
`define OFS_SC2        3'h1
`define OFS_SC1        3'h2
`define OFS_RES_HI     3'h3
`define OFS_RES_LO     3'h4
`define OFS_CMP_HI     3'h5
`define OFS_CMP_LO     3'h6
`define OFS_STOP_CTL   3'h7

`define CFG_LPC        7
`define CFG_DIV_HI     6
`define CFG_DIV_LO     5
`define CFG_LSMP       4
`define CFG_MODE_HI    3
`define CFG_MODE_LO    2
`define CFG_ICLK_HI    1
`define CFG_ICLK_LO    0

`define SC2_ACT        7
`define SC2_TRG        6
`define SC2_CFE        5
`define SC2_CGT        4

`define SC1_CONVERSION_COMPLETE_FLAG       7
`define SC1_COMPLETE_IRQ_ENABLE       6
`define SC1_CONTINUOUS_CONVERSION_ENABLE       5
`define SC1_CH_HI      4

`define ICLK_ASYNC     2'h3
`define MODE_10BIT     2'h2
`define CH_OFF         5'h1F
`define RST_BYTE       8'h00
`define RST_CH         5'h1F

`define SAMPLE_SHORT   8'h04
`define SAMPLE_LONG    8'h18
`define BITS_8         8'h08
`define BITS_10        8'h0A
`define BITS_12        8'h0C
`define DIV_ZERO       4'h0

`endif

// ### adc_lp_pkg.sv
/*
 * types shared by the converter control block; assumes the defs header
 */
package adc_lp_pkg;
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b001,
        ST_SAMPLE = 3'b010,
        ST_CONV   = 3'b100
    } conv_state_t;
endpackage

// ### adc_lowpower_config_control.sv
/*
 * converter control: registers over avalon-mm, conversion sequencer with
 * stop3/stop1-2 handling, blocking of results during split reads.
 * assumes a power manager drives the stop inputs synchronously, an analog
 * core result arrives as a bus input, and the hw trigger is an async pin.
 */
`timescale 1ns/10ps
`include "adc_lp_defs.svh"

// Contract
// - stop3 without async clock aborts to idle
// - stop3 entry/exit keeps result bytes
// - after abort, wait for fresh trigger
// - async clock selected: keep running in stop3
// - running conversion completes in stop3 only with async clock selected
// - stop3 starts on hw trigger or continuous
// - completion sets flag, irq when enabled
// - deep stop disables, registers reset
// - configuration register field layout
// - divider 00 undivided, source 00 bus
// - mode 10 gives ten-bit conversion
// - sc2 bit7 shows conversion active
// - sc2 bit6 selects trigger, 0 software
// - sc2 bit5 compare enable, bit4 direction
// - sc2 bits3:0 read zero
// - sc1 bit7 completion flag, bit6 irq enable
// - sc1 bit5 continuous, else one per trigger
// - sc1 bits4:0 channel select
// - split read blocks and discards result
module adc_lowpower_config_control
    import adc_lp_pkg::*;
#(
    parameter int CNT_W = 8
) (
    input  wire logic        ref_clk,
    input  wire logic        rst_b,
    input  wire logic [2:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        stop3_mode,
    input  wire logic        deep_stop_mode,
    input  wire logic        async_conv_clock_tick,
    input  wire logic        hw_trigger_pin,
    input  wire logic [11:0] analog_result,
    output logic             complete_irq,
    output logic             wake_request,
    output logic [4:0]       input_channel_select,
    output logic             conversion_clock_on
);

    conv_state_t       state_q, state_d;
    logic [7:0]        cfg_q;
    logic [7:0]        sc2_q;
    logic [6:0]        sc1_q;
    logic              conversion_complete_flag_q;
    logic [7:0]        res_hi_q, res_lo_q;
    logic [7:0]        cmp_hi_q, cmp_lo_q;
    logic              hi_read_q;
    logic [CNT_W-1:0]  cnt_q;
    logic [3:0]        div_q;
    logic              trg_s1_q, trg_s2_q, trg_s3_q;
    logic              ack_s1_q, ack_s2_q, ack_s3_q;
    logic              bus_ack_q;
    logic [31:0]       rdata_q;
    logic              irq_q, wake_q, clkon_q;
    logic              wait_q;             // registered waitrequest, idle high

    // clock divider ratio minus one for a divider code
    function automatic logic [3:0] div_last(input logic [1:0] code);
        div_last = (4'h1 << code) - 4'h1;
    endfunction

    // conversion cycles after sampling, by resolution code
    function automatic logic [7:0] conv_len(input logic [1:0] mode);
        case (mode)
            2'h0:    conv_len = `BITS_8;
            2'h2:    conv_len = `BITS_10;
            default: conv_len = `BITS_12;
        endcase
    endfunction

    // decode of the bus access
    wire        wr_hit     = avs_write && !bus_ack_q;
    wire        rd_hit     = avs_read && !bus_ack_q;
    wire        wr_cfg     = wr_hit && avs_address == `OFS_CFG;
    wire        wr_sc2     = wr_hit && avs_address == `OFS_SC2;
    wire        wr_sc1     = wr_hit && avs_address == `OFS_SC1;
    wire        wr_cmp     = wr_hit && (avs_address == `OFS_CMP_HI ||
                                        avs_address == `OFS_CMP_LO);
    wire        rd_hi      = rd_hit && avs_address == `OFS_RES_HI;
    wire        rd_lo      = rd_hit && avs_address == `OFS_RES_LO;
    wire        rd_sc1     = rd_hit && avs_address == `OFS_SC1;

    // clock source and activity decode
    wire        async_sel  = cfg_q[`CFG_ICLK_HI:`CFG_ICLK_LO] == `ICLK_ASYNC;
    wire        ack_edge   = ack_s2_q && !ack_s3_q;
    wire        in_tick    = async_sel ? ack_edge : 1'b1;
    wire        halted     = stop3_mode && !async_sel;
    wire        conversion_clock_tick  = in_tick && !halted && div_q == `DIV_ZERO;
    wire        trg_edge   = trg_s2_q && !trg_s3_q;
    wire        hw_mode    = sc2_q[`SC2_TRG];
    wire        cont_mode  = sc1_q[`SC1_CONTINUOUS_CONVERSION_ENABLE];
    wire        ch_on      = sc1_q[4:0] != `CH_OFF;
    wire        sw_start   = wr_sc1 && avs_writedata[4:0] != `CH_OFF && !hw_mode;
    wire        hw_start   = hw_mode && trg_edge && ch_on && !halted;
    wire        abort      = wr_cfg || wr_sc2 || wr_cmp || wr_sc1 || halted;
    wire [7:0]  samp_len   = cfg_q[`CFG_LSMP] ? `SAMPLE_LONG : `SAMPLE_SHORT;
    wire        active     = state_q != ST_IDLE;
    wire        conv_done  = state_q == ST_CONV && conversion_clock_tick &&
                             cnt_q == CNT_W'(conv_len(cfg_q[`CFG_MODE_HI:`CFG_MODE_LO]));

    // compare function: result minus compare value
    wire [11:0] cmp_val    = {cmp_hi_q[3:0], cmp_lo_q};
    wire [11:0] diff       = analog_result - cmp_val;
    wire        ge         = analog_result >= cmp_val;
    wire        cmp_true   = sc2_q[`SC2_CGT] ? ge : !ge;
    wire        cmp_en     = sc2_q[`SC2_CFE];
    wire [11:0] xfer_val   = cmp_en ? diff : analog_result;
    wire        want_xfer  = conv_done && (!cmp_en || cmp_true);
    wire        blocked    = hi_read_q;
    wire        do_xfer    = want_xfer && !blocked;
    wire        restart    = conv_done && ((blocked && want_xfer) ||
                                           cont_mode || (blocked && !cmp_en));
    wire        set_conversion_complete_flag   = do_xfer;

    // sequencer next state
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (sw_start || hw_start) begin
                    state_d = ST_SAMPLE;
                end
            end
            ST_SAMPLE: begin
                if (conversion_clock_tick && cnt_q == CNT_W'(samp_len)) begin
                    state_d = ST_CONV;
                end
            end
            ST_CONV: begin
                if (conv_done) begin
                    state_d = (restart && (!hw_mode || cont_mode || blocked))
                              ? ST_SAMPLE : ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;
        endcase
        if (abort && !sw_start) begin
            state_d = ST_IDLE;
        end else if (abort && sw_start) begin
            state_d = ST_SAMPLE;
        end
    end

    // pin synchronisers
    always_ff @(posedge ref_clk) begin
        trg_s1_q <= hw_trigger_pin;
        trg_s2_q <= trg_s1_q;
        trg_s3_q <= trg_s2_q;
        ack_s1_q <= async_conv_clock_tick;
        ack_s2_q <= ack_s1_q;
        ack_s3_q <= ack_s2_q;
    end

    // sequencer, divider and phase counter
    always_ff @(posedge ref_clk) begin
        if (!rst_b || deep_stop_mode) begin
            state_q <= ST_IDLE;
            cnt_q   <= '0;
            div_q   <= `DIV_ZERO;
        end else begin
            state_q <= state_d;
            if (in_tick && !halted) begin
                div_q <= (div_q == `DIV_ZERO) ?
                         div_last(cfg_q[`CFG_DIV_HI:`CFG_DIV_LO]) : div_q - 4'h1;
            end
            if (state_d != state_q || !active) begin
                cnt_q <= '0;
            end else if (conversion_clock_tick) begin
                cnt_q <= cnt_q + CNT_W'(1);
            end
        end
    end

    // configuration registers
    always_ff @(posedge ref_clk) begin
        if (!rst_b || deep_stop_mode) begin
            cfg_q    <= `RST_BYTE;
            sc2_q    <= `RST_BYTE;
            sc1_q    <= {2'h0, `RST_CH};
            cmp_hi_q <= `RST_BYTE;
            cmp_lo_q <= `RST_BYTE;
        end else begin
            if (wr_cfg) begin
                cfg_q <= avs_writedata[7:0];
            end
            if (wr_sc2) begin
                sc2_q <= {1'b0, avs_writedata[6:4], 4'h0};
            end
            if (wr_sc1) begin
                sc1_q <= avs_writedata[6:0];
            end
            if (wr_hit && avs_address == `OFS_CMP_HI) begin
                cmp_hi_q <= avs_writedata[7:0];
            end
            if (wr_hit && avs_address == `OFS_CMP_LO) begin
                cmp_lo_q <= avs_writedata[7:0];
            end
        end
    end

    // results, completion flag and read blocking; stop3 leaves them alone
    always_ff @(posedge ref_clk) begin
        if (!rst_b || deep_stop_mode) begin
            res_hi_q  <= `RST_BYTE;
            res_lo_q  <= `RST_BYTE;
            conversion_complete_flag_q    <= 1'b0;
            hi_read_q <= 1'b0;
        end else begin
            if (do_xfer) begin
                res_hi_q <= {4'h0, xfer_val[11:8]};
                res_lo_q <= xfer_val[7:0];
            end
            if (set_conversion_complete_flag) begin
                conversion_complete_flag_q <= 1'b1;
            end else if (wr_sc1 || rd_lo || wr_cfg || wr_sc2 || wr_cmp) begin
                conversion_complete_flag_q <= 1'b0;
            end
            if (rd_lo) begin
                hi_read_q <= 1'b0;
            end else if (rd_hi && cfg_q[`CFG_MODE_HI:`CFG_MODE_LO] != 2'h0) begin
                hi_read_q <= 1'b1;
            end
        end
    end

    // read data mux
    wire [31:0] rd_mux =
        (avs_address == `OFS_CFG)      ? {24'h0, cfg_q} :
        (avs_address == `OFS_SC2)      ? {24'h0, active, sc2_q[6:4], 4'h0} :
        (avs_address == `OFS_SC1)      ? {24'h0, conversion_complete_flag_q, sc1_q} :
        (avs_address == `OFS_RES_HI)   ? {24'h0, res_hi_q} :
        (avs_address == `OFS_RES_LO)   ? {24'h0, res_lo_q} :
        (avs_address == `OFS_CMP_HI)   ? {24'h0, cmp_hi_q} :
        (avs_address == `OFS_CMP_LO)   ? {24'h0, cmp_lo_q} :
        {30'h0, stop3_mode, deep_stop_mode};

    // bus answer one cycle after the request, outputs registered
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            bus_ack_q <= 1'b0;
            wait_q    <= 1'b1;
            rdata_q   <= 32'h0;
            irq_q     <= 1'b0;
            wake_q    <= 1'b0;
            clkon_q   <= 1'b0;
        end else begin
            bus_ack_q <= (avs_read || avs_write) && !bus_ack_q;
            wait_q    <= !((avs_read || avs_write) && !bus_ack_q); // mirrors the answer flop
            if (rd_hit) begin
                rdata_q <= rd_mux;
            end
            irq_q   <= conversion_complete_flag_q && sc1_q[`SC1_COMPLETE_IRQ_ENABLE] && !deep_stop_mode;
            wake_q  <= conversion_complete_flag_q && sc1_q[`SC1_COMPLETE_IRQ_ENABLE] && stop3_mode && !deep_stop_mode;
            clkon_q <= active && !deep_stop_mode;
        end
    end

    assign avs_readdata         = rdata_q;
    assign avs_waitrequest      = wait_q;
    assign complete_irq         = irq_q;
    assign wake_request         = wake_q;
    assign input_channel_select = sc1_q[4:0];
    assign conversion_clock_on  = clkon_q;

endmodule // adc_lowpower_config_control

// ### adc_lp_sva.sv
/* checker of the converter control block: bus answer, stop and reset behaviour
   assumes it is bound to the top module and sees only its ports */
`timescale 1ns/10ps
`include "adc_lp_defs.svh"
module adc_lp_sva (
    input wire logic        ref_clk,
    input wire logic        rst_b,
    input wire logic [2:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        stop3_mode,
    input wire logic        deep_stop_mode,
    input wire logic        complete_irq,
    input wire logic        wake_request,
    input wire logic [4:0]  input_channel_select,
    input wire logic        conversion_clock_on
);
    logic [1:0] clk_src_q;
    logic       irq_en_q;
    wire        cfg_wr = avs_write && !avs_waitrequest && avs_address == `OFS_CFG;
    wire        sc1_wr = avs_write && !avs_waitrequest && avs_address == `OFS_SC1;
    // shadow of clock source and irq enable, cleared like the registers
    always_ff @(posedge ref_clk) begin
        if (!rst_b || deep_stop_mode) begin
            clk_src_q <= 2'h0;
            irq_en_q  <= 1'b0;
        end else begin
            if (cfg_wr) clk_src_q <= avs_writedata[1:0];
            if (sc1_wr) irq_en_q <= avs_writedata[`SC1_COMPLETE_IRQ_ENABLE];
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    req_answer_a: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest)
        else $error("request not answered in one cycle");
    wait_single_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("answer held longer than one cycle");
    read_zero_a: assert property (avs_read && !avs_waitrequest && avs_address == `OFS_SC2
        |-> avs_readdata[3:0] == 4'h0) else $error("reserved bits not zero");
    deep_clear_a: assert property (deep_stop_mode |=> !complete_irq && !conversion_clock_on
        && input_channel_select == `RST_CH) else $error("deep stop left state");
    wake_stop_a: assert property (wake_request |-> $past(stop3_mode))
        else $error("wake outside stop");
    abort_idle_a: assert property ($rose(stop3_mode) && clk_src_q != `ICLK_ASYNC
        |-> ##[1:3] !conversion_clock_on) else $error("stop did not abort");
    chan_write_a: assert property (sc1_wr
        |=> input_channel_select == $past(avs_writedata[4:0])) else $error("channel wrong");
    irq_gate_a: assert property (complete_irq |-> irq_en_q || $past(irq_en_q))
        else $error("irq while disabled");
endmodule // adc_lp_sva
bind adc_lowpower_config_control adc_lp_sva adc_lp_sva_inst (.ref_clk(ref_clk),
    .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .stop3_mode(stop3_mode),
    .deep_stop_mode(deep_stop_mode), .complete_irq(complete_irq),
    .wake_request(wake_request), .input_channel_select(input_channel_select),
    .conversion_clock_on(conversion_clock_on));

// ### adc_lowpower_config_control_bench.sv
/* testbench of the converter control block: registers, triggers, stop modes
   assumes the design and its checker are compiled before it */
`timescale 1ns/10ps
`include "adc_lp_defs.svh"
module adc_lowpower_config_control_bench;
    logic        ref_clk, rst_b, avs_read, avs_write, stop3_mode, deep_stop_mode;
    logic        tick_en, async_conv_clock_tick, hw_trigger_pin;
    logic [2:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [11:0] analog_result;
    logic [4:0]  input_channel_select;
    logic        avs_waitrequest, complete_irq, wake_request, conversion_clock_on;
    logic [7:0]  rd_v;
    int          failures = 0;
    int          tests_run = 0;
    adc_lowpower_config_control adc_lowpower_config_control_inst (.ref_clk(ref_clk),
        .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .stop3_mode(stop3_mode),
        .deep_stop_mode(deep_stop_mode), .async_conv_clock_tick(async_conv_clock_tick),
        .hw_trigger_pin(hw_trigger_pin), .analog_result(analog_result),
        .complete_irq(complete_irq), .wake_request(wake_request),
        .input_channel_select(input_channel_select),
        .conversion_clock_on(conversion_clock_on));
    // bus clock and the async conversion clock, ticking every other cycle
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) async_conv_clock_tick <= tick_en & ~async_conv_clock_tick;
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one avalon access, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_read <= !w;
        avs_write <= w;
        do begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 40);
        if (avs_waitrequest !== 1'b0) failures++;
        rd_v = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic wait_hi(input logic sel, input int lim);
        int n;
        n = 0;
        while ((sel ? wake_request : complete_irq) !== 1'b1 && n < lim) begin
            @(posedge ref_clk);
            n++;
        end
    endtask
    task automatic pulse_trig();
        hw_trigger_pin <= 1'b1;
        repeat (4) @(posedge ref_clk);
        hw_trigger_pin <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask
    task automatic t_reset_fields();
        bus(0, `OFS_SC1, 0); chk("sc1", 8'h1F, rd_v);
        bus(0, `OFS_STOP_CTL, 0); chk("stop", 8'h00, rd_v);
        bus(1, `OFS_CFG, 8'h98); bus(0, `OFS_CFG, 0); chk("cfg", 8'h98, rd_v);
        bus(1, `OFS_SC2, 8'h30); bus(0, `OFS_SC2, 0); chk("sc2", 8'h30, rd_v);
        bus(1, `OFS_SC2, 8'h00); bus(0, `OFS_SC2, 0); chk("sc2", 8'h00, rd_v);
    endtask
    task automatic t_single();
        analog_result <= 12'h2A5;
        bus(1, `OFS_SC1, 8'h41); chk("chan", 8'h01, input_channel_select);
        bus(0, `OFS_SC2, 0); chk("act", 8'h01, rd_v[7]);
        wait_hi(0, 200); chk("irq", 8'h01, complete_irq);
        bus(0, `OFS_SC1, 0); chk("sc1", 8'hC1, rd_v);
        bus(0, `OFS_RES_HI, 0); chk("hi", 8'h02, rd_v);
        bus(0, `OFS_RES_LO, 0); chk("lo", 8'hA5, rd_v);
        repeat (100) @(posedge ref_clk);
        chk("irq", 8'h00, complete_irq);
        bus(0, `OFS_SC2, 0); chk("act", 8'h00, rd_v[7]);
    endtask
    task automatic t_hw_abort();
        analog_result <= 12'h3C3;
        bus(1, `OFS_SC2, 8'h40); bus(1, `OFS_SC1, 8'h41);
        repeat (20) @(posedge ref_clk);
        chk("on", 8'h00, conversion_clock_on);
        pulse_trig();
        stop3_mode <= 1'b1;
        repeat (5) @(posedge ref_clk);
        chk("on", 8'h00, conversion_clock_on);
        stop3_mode <= 1'b0;
        repeat (100) @(posedge ref_clk);
        chk("irq", 8'h00, complete_irq);
        bus(0, `OFS_RES_HI, 0); chk("hi", 8'h02, rd_v);
        bus(0, `OFS_RES_LO, 0); chk("lo", 8'hA5, rd_v);
        pulse_trig();
        wait_hi(0, 200); chk("irq", 8'h01, complete_irq);
        bus(0, `OFS_RES_HI, 0); chk("hi", 8'h03, rd_v);
        bus(0, `OFS_RES_LO, 0); chk("lo", 8'hC3, rd_v);
    endtask
    task automatic t_async();
        analog_result <= 12'h155;
        tick_en <= 1'b1;
        bus(1, `OFS_CFG, 8'h0B); bus(1, `OFS_SC2, 8'h00); bus(1, `OFS_SC1, 8'h61);
        stop3_mode <= 1'b1;
        wait_hi(1, 600); chk("wake", 8'h01, wake_request);
        bus(0, `OFS_RES_HI, 0); chk("hi", 8'h01, rd_v);
        bus(0, `OFS_RES_LO, 0); chk("lo", 8'h55, rd_v);
        repeat (3) @(posedge ref_clk);
        wait_hi(1, 600); chk("wake", 8'h01, wake_request);
        bus(1, `OFS_SC1, 8'h1F);
        stop3_mode <= 1'b0;
        tick_en <= 1'b0;
    endtask
    task automatic t_deep();
        bus(1, `OFS_CFG, 8'h98); bus(1, `OFS_SC1, 8'h41);
        deep_stop_mode <= 1'b1;
        repeat (2) @(posedge ref_clk);
        deep_stop_mode <= 1'b0;
        @(posedge ref_clk);
        bus(0, `OFS_CFG, 0); chk("cfg", 8'h00, rd_v);
        bus(0, `OFS_SC1, 0); chk("sc1", 8'h1F, rd_v);
        bus(1, `OFS_CFG, 8'h98); bus(0, `OFS_CFG, 0); chk("cfg", 8'h98, rd_v);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // watchdog sized well above the expected run
    initial begin
        #(100 * 20000);
        failures++;
        close_out();
    end
    // reset, then the scenarios in turn
    initial begin
        {rst_b, avs_read, avs_write, stop3_mode, deep_stop_mode, tick_en} = 6'h00;
        {hw_trigger_pin, avs_address} = 4'h0;
        avs_writedata = 32'h0;
        analog_result = 12'h000;
        repeat (8) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(posedge ref_clk);
        t_reset_fields();
        t_single();
        t_hw_abort();
        t_async();
        t_deep();
        close_out();
    end
endmodule // adc_lowpower_config_control_bench
